// *** design/wdlp_defines.vh ***
// constants for the watchdog and low-power wake controller
`ifndef WDLP_DEFINES_VH
`define WDLP_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define WDLP_ADDR_WD_CTRL    4'h0
`define WDLP_ADDR_WD_KEY     4'h1
`define WDLP_ADDR_WD_COUNT   4'h2
`define WDLP_ADDR_LP_CTRL    4'h3
`define WDLP_ADDR_WAKE_SEL   4'h4
`define WDLP_ADDR_STATUS     4'h5
`define WDLP_ADDR_LP_ENTER   4'h6

// ----------------------------------------
// fields and values
// ----------------------------------------
`define WDLP_KEY_FIRST       8'h55
`define WDLP_KEY_SECOND      8'hAA
`define WDLP_WDC_ENABLE      0
`define WDLP_WDC_RESET_SEL   1
`define WDLP_WDC_RST         2'h0
`define WDLP_LPC_RST         8'h00
`define WDLP_WAKE_SEL_RST    32'h00000000
`define WDLP_MODE_IDLE       2'h0
`define WDLP_MODE_STANDBY    2'h1
`define WDLP_PULSE_CYCLES    10'h200
`define WDLP_COUNT_MAX       8'hFF

`endif

// *** design/wdlp_sync.v ***
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/100ps
module wdlp_sync #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b1}}
) (
  input  wire         i_clock,
  input  wire         i_resetn,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar g;

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit changes only once stages two and three agree
  generate
    for (g = 0; g < W; g = g + 1) begin : g_agree
      always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          o_sync[g] <= RST[g];
        end else if (s2_r[g] == s3_r[g]) begin
          o_sync[g] <= s3_r[g];
        end
      end
    end
  endgenerate
endmodule // wdlp_sync

// *** design/wdlp_top.v ***
// watchdog counter, key sequence and low-power mode / wake control
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "wdlp_defines.vh"

// Function
// - counter at maximum emits a pulse 512 oscillator clocks long
// - key write 0x55 then 0xAA clears the counter; software services or disables
// - expiry gives device reset or wake interrupt, chosen by configuration
// - counter holds while only the limp-mode clock is present
// - watchdog reset output is active low for 512 cycles
// - in STANDBY only the watchdog runs; its interrupt may wake the device
// - in IDLE the wake interrupt goes to the interrupt expander
// - in HALT the watchdog wakes the device only through reset
// - mode field 00 IDLE, 01 STANDBY, 1X HALT
// - clock gating per mode: IDLE all on, STANDBY osc and PLL only, HALT none
// - IDLE exits on external reset, watchdog interrupt or enabled interrupt
// - STANDBY exits on external reset, watchdog, selected port A pin, debugger
// - HALT exits on external reset, selected port A pin, debugger, watchdog
// - wake sources are active low and must be held long enough
// - HALT entry requires the watchdog clock active
// - any of 32 port A lines selectable as wake source by one mask
// - wake pins qualified over a programmable number of oscillator clocks
// - with mode IDLE the low-power block takes no action of its own; the code still freezes o_pin_out while in IDLE
// - output pins keep their state across low-power entry and exit
module wdlp_top (
  input  wire        i_clock,
  input  wire        i_resetn,
  input  wire [3:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire        i_clock_fail,
  input  wire        i_wd_clock_active,
  input  wire        i_ext_reset_n,
  input  wire        i_debug_wake_n,
  input  wire        i_cpu_irq_n,
  input  wire [31:0] i_gpio_a,
  input  wire [31:0] i_pin_out,
  output reg  [31:0] o_rdata,
  output reg         o_wd_reset_n,
  output wire        o_wd_wake_irq_n,
  output wire        o_expander_irq_n,
  output reg         o_osc_clock_en,
  output reg         o_cpu_clock_in_en,
  output reg         o_system_clock_out_en,
  output reg         o_pll_en,
  output reg  [31:0] o_pin_out
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] ST_RUN     = 4'h1;
  localparam [3:0] ST_IDLE    = 4'h2;
  localparam [3:0] ST_STANDBY = 4'h4;
  localparam [3:0] ST_HALT    = 4'h8;

  reg  [1:0]  wd_ctrl_r;
  reg         key_armed_r;
  reg  [7:0]  wd_count_r;
  reg  [9:0]  pulse_cnt_r;
  reg         pulse_r;
  reg  [7:0]  lp_ctrl_r;
  reg  [31:0] wake_sel_r;
  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [7:0]  qual_cnt_r;
  reg         was_wd_reset_r;
  reg         halt_refused_r;
  wire        clock_fail_s;
  wire        wd_clk_s;
  wire        ext_rst_n_s;
  wire        dbg_n_s;
  wire        cpu_irq_n_s;
  wire [31:0] gpio_s;
  wire        key_write;
  wire        key_clear;
  wire        expire;
  wire        pin_wake_raw;
  wire        pin_wake;
  wire        wd_irq;
  wire        wd_rst_sel;
  wire [31:0] pin_low;
  genvar      g;

  function is_addr;
    input [3:0] a;
    input [3:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // cpu and system clocks run only in RUN and IDLE
  function clocks_on;
    input [3:0] s;
    begin
      clocks_on = (s == ST_RUN) || (s == ST_IDLE);
    end
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  wdlp_sync #(.W(37), .RST({32'hFFFFFFFF, 5'h1E})) u_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_async  ({i_gpio_a, i_ext_reset_n, i_debug_wake_n, i_cpu_irq_n,
                i_wd_clock_active, i_clock_fail}),
    .o_sync   ({gpio_s, ext_rst_n_s, dbg_n_s, cpu_irq_n_s, wd_clk_s, clock_fail_s})
  );

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  assign key_write  = i_wr && is_addr(i_addr, `WDLP_ADDR_WD_KEY);
  assign key_clear  = key_write && key_armed_r &&
                      (i_wdata[7:0] == `WDLP_KEY_SECOND);
  assign expire     = wd_ctrl_r[`WDLP_WDC_ENABLE] && !clock_fail_s &&
                      (wd_count_r == `WDLP_COUNT_MAX) && !pulse_r;
  assign wd_rst_sel = wd_ctrl_r[`WDLP_WDC_RESET_SEL];

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      key_armed_r <= 1'b0;
    end else if (key_write) begin
      // any other value breaks the pair
      key_armed_r <= (i_wdata[7:0] == `WDLP_KEY_FIRST);
    end
  end

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wd_count_r <= 8'h00;
    end else if (key_clear || !wd_ctrl_r[`WDLP_WDC_ENABLE]) begin
      wd_count_r <= 8'h00;
    end else if (clock_fail_s) begin
      wd_count_r <= wd_count_r;
    end else if (expire) begin
      wd_count_r <= 8'h00;
    end else if (!pulse_r) begin
      wd_count_r <= wd_count_r + 8'h01;
    end
  end

  // pulse length is fixed and not shortened by a service write
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pulse_r     <= 1'b0;
      pulse_cnt_r <= 10'h000;
    end else if (expire) begin
      pulse_r     <= 1'b1;
      pulse_cnt_r <= `WDLP_PULSE_CYCLES - 10'h001;
    end else if (pulse_r) begin
      if (pulse_cnt_r == 10'h000) begin
        pulse_r <= 1'b0;
      end else begin
        pulse_cnt_r <= pulse_cnt_r - 10'h001;
      end
    end
  end

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wd_reset_n <= 1'b1;
    end else begin
      o_wd_reset_n <= !(expire || (pulse_r && pulse_cnt_r != 10'h000)) || !wd_rst_sel;
    end
  end

  // in HALT the interrupt path is dead; reset is the only way out
  assign wd_irq          = pulse_r && !wd_rst_sel && (state_r != ST_HALT);
  assign o_wd_wake_irq_n = !wd_irq;
  assign o_expander_irq_n = !(wd_irq && clocks_on(state_r));

  // ----------------------------------------
  // low-power mode control
  // ----------------------------------------
  // ----------------------------------------
  // wake qualification
  // ----------------------------------------
  // qualification filters glitches on wake pins; a short low pulse is ignored
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_pin
      assign pin_low[g] = !gpio_s[g] && wake_sel_r[g];
    end
  endgenerate
  assign pin_wake_raw = |pin_low;
  assign pin_wake     = pin_wake_raw && (qual_cnt_r >= lp_ctrl_r[7:2]);

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      qual_cnt_r <= 8'h00;
    end else if (!pin_wake_raw || clocks_on(state_r)) begin
      qual_cnt_r <= 8'h00;
    end else if (qual_cnt_r != 8'hFF) begin
      qual_cnt_r <= qual_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------
  // mode state machine
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (i_wr && is_addr(i_addr, `WDLP_ADDR_LP_ENTER)) begin
          if (lp_ctrl_r[1]) begin
            if (wd_clk_s) begin
              state_nxt = ST_HALT;
            end
          end else if (lp_ctrl_r[0]) begin
            state_nxt = ST_STANDBY;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (!ext_rst_n_s || wd_irq || !cpu_irq_n_s) begin
          state_nxt = ST_RUN;
        end
      end
      ST_STANDBY: begin
        if (!ext_rst_n_s || wd_irq || pin_wake || !dbg_n_s) begin
          state_nxt = ST_RUN;
        end
      end
      ST_HALT: begin
        if (!ext_rst_n_s || pin_wake || !dbg_n_s || !o_wd_reset_n) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // clock gating
  // ----------------------------------------
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_osc_clock_en        <= 1'b1;
      o_cpu_clock_in_en     <= 1'b1;
      o_system_clock_out_en <= 1'b1;
      o_pll_en              <= 1'b1;
    end else begin
      o_osc_clock_en        <= (state_nxt != ST_HALT);
      o_pll_en              <= (state_nxt != ST_HALT);
      o_cpu_clock_in_en     <= clocks_on(state_nxt);
      o_system_clock_out_en <= clocks_on(state_nxt);
    end
  end

  // ----------------------------------------
  // output pins
  // ----------------------------------------
  // pins follow software only while running; frozen in any low-power mode
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin_out <= 32'h00000000;
    end else if (state_r == ST_RUN && state_nxt == ST_RUN) begin
      o_pin_out <= i_pin_out;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wd_ctrl_r  <= `WDLP_WDC_RST;
      lp_ctrl_r  <= `WDLP_LPC_RST;
      wake_sel_r <= `WDLP_WAKE_SEL_RST;
    end else if (i_wr) begin
      if (is_addr(i_addr, `WDLP_ADDR_WD_CTRL)) begin
        wd_ctrl_r <= i_wdata[1:0];
      end
      if (is_addr(i_addr, `WDLP_ADDR_LP_CTRL)) begin
        lp_ctrl_r <= i_wdata[7:0];
      end
      if (is_addr(i_addr, `WDLP_ADDR_WAKE_SEL)) begin
        wake_sel_r <= i_wdata;
      end
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // sticky watchdog reset flag; set wins over a clear write
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      was_wd_reset_r <= 1'b0;
    end else if (expire && wd_rst_sel) begin
      was_wd_reset_r <= 1'b1;
    end else if (i_wr && is_addr(i_addr, `WDLP_ADDR_STATUS) && i_wdata[0]) begin
      was_wd_reset_r <= 1'b0;
    end
  end

  // a refused halt entry leaves no trace in the clocks, so software sees it here
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      halt_refused_r <= 1'b0;
    end else if (i_wr && is_addr(i_addr, `WDLP_ADDR_LP_ENTER) && state_r == ST_RUN &&
                 lp_ctrl_r[1] && !wd_clk_s) begin
      halt_refused_r <= 1'b1;
    end else if (i_wr && is_addr(i_addr, `WDLP_ADDR_STATUS) && i_wdata[3]) begin
      halt_refused_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `WDLP_ADDR_WD_CTRL:  o_rdata <= {30'h00000000, wd_ctrl_r};
        `WDLP_ADDR_WD_COUNT: o_rdata <= {24'h000000, wd_count_r};
        `WDLP_ADDR_LP_CTRL:  o_rdata <= {24'h000000, lp_ctrl_r};
        `WDLP_ADDR_WAKE_SEL: o_rdata <= wake_sel_r;
        `WDLP_ADDR_STATUS:   o_rdata <= {24'h000000, state_r, halt_refused_r, key_armed_r,
                                         pulse_r, was_wd_reset_r};
        default:             o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule // wdlp_top

// *** dv/wdlp_assertions.sv ***
// concurrent checks on the watchdog and low-power wake controller ports
`timescale 1ns/100ps
module wdlp_assertions (
  input wire        i_clock,
  input wire        i_resetn,
  input wire        o_wd_reset_n,
  input wire        o_wd_wake_irq_n,
  input wire        o_expander_irq_n,
  input wire        o_osc_clock_en,
  input wire        o_cpu_clock_in_en,
  input wire        o_system_clock_out_en,
  input wire        o_pll_en,
  input wire [31:0] o_pin_out
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------
  // low-time counters, saturate so a stuck output cannot wrap
  // ----------------------------------------
  logic [9:0] rst_lo_r;
  logic [9:0] irq_lo_r;
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_lo_r <= 10'h000;
      irq_lo_r <= 10'h000;
    end else begin
      rst_lo_r <= o_wd_reset_n ? 10'h000 : rst_lo_r + {9'h000, rst_lo_r != 10'h3FF};
      irq_lo_r <= o_wd_wake_irq_n ? 10'h000 : irq_lo_r + {9'h000, irq_lo_r != 10'h3FF};
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  reset_width_a: assert property ($rose(o_wd_reset_n) |-> rst_lo_r == 10'h200)
    else $error("watchdog reset low time is not 512 cycles");
  reset_max_a: assert property (rst_lo_r <= 10'h200)
    else $error("watchdog reset held low too long");
  wake_width_a: assert property ($rose(o_wd_wake_irq_n) |-> irq_lo_r == 10'h200)
    else $error("wake interrupt low time is not 512 cycles");
  one_action_a: assert property (o_wd_reset_n || o_wd_wake_irq_n)
    else $error("reset and wake interrupt both active");
  halt_noirq_a: assert property (!o_osc_clock_en |-> o_wd_wake_irq_n)
    else $error("wake interrupt active in halt");
  expander_a: assert property (!o_expander_irq_n |-> !o_wd_wake_irq_n)
    else $error("expander interrupt without wake interrupt");
  clock_gate_a: assert property (o_cpu_clock_in_en == o_system_clock_out_en &&
    o_pll_en == o_osc_clock_en && (o_osc_clock_en || !o_cpu_clock_in_en))
    else $error("clock enables inconsistent with any mode");
  pin_hold_a: assert property (!o_cpu_clock_in_en && $past(!o_cpu_clock_in_en)
    |-> $stable(o_pin_out))
    else $error("output pins changed in low-power mode");
  cover property ($fell(o_wd_reset_n));
  cover property ($fell(o_wd_wake_irq_n));
  cover property ($fell(o_pll_en));
  cover property ($rose(o_cpu_clock_in_en));
endmodule // wdlp_assertions

bind wdlp_top wdlp_assertions i_wdlp_assertions (.*);

// *** dv/wdlp_partner.sv ***
// far-side model: port A pins, external reset, debugger and cpu interrupt lines
`timescale 1ns/100ps
module wdlp_partner (
  input  wire        i_clock,
  input  wire [31:0] i_noise,
  input  wire [31:0] i_quiet,
  output wire [31:0] o_gpio_a,
  output wire        o_ext_reset_n,
  output wire        o_debug_wake_n,
  output wire        o_cpu_irq_n
);
  reg [34:0] low_r = 35'h0;
  // unselected pins toggle freely so a mask fault shows as a false wake
  assign o_gpio_a       = (i_noise | i_quiet) & ~low_r[31:0];
  assign o_ext_reset_n  = ~low_r[32];
  assign o_debug_wake_n = ~low_r[33];
  assign o_cpu_irq_n    = ~low_r[34];
  // active-low wake line held for len cycles; short holds must be ignored
  task automatic hold_low(input int idx, input int len);
    @(posedge i_clock);
    low_r[idx] <= 1'b1;
    repeat (len) @(posedge i_clock);
    low_r[idx] <= 1'b0;
  endtask
endmodule // wdlp_partner

// *** dv/wdlp_top_tb.sv ***
// self-checking bench for the watchdog and low-power wake controller
`timescale 1ns/100ps
`include "wdlp_defines.vh"
module wdlp_top_tb;
  logic        i_clock, i_resetn, i_wr, i_rd, i_clock_fail, i_wd_clock_active;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata, i_pin_out, noise, v, pin_keep;
  wire  [31:0] gpio_a, o_rdata, o_pin_out;
  wire         ext_n, dbg_n, irq_n, o_wd_reset_n, o_wd_wake_irq_n, o_expander_irq_n;
  wire         o_osc_clock_en, o_cpu_clock_in_en, o_system_clock_out_en, o_pll_en;
  integer      seed = 32'hA1BD8F67;
  int          num_errors = 0, checks = 0, cyc = 0, n;
  logic        rd_seen = 1'b0;
  logic [31:0] exp_q[$];

  wdlp_top i_wdlp_top (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_clock_fail(i_clock_fail),
    .i_wd_clock_active(i_wd_clock_active), .i_ext_reset_n(ext_n), .i_debug_wake_n(dbg_n),
    .i_cpu_irq_n(irq_n), .i_gpio_a(gpio_a), .i_pin_out(i_pin_out), .o_rdata(o_rdata),
    .o_wd_reset_n(o_wd_reset_n), .o_wd_wake_irq_n(o_wd_wake_irq_n),
    .o_expander_irq_n(o_expander_irq_n), .o_osc_clock_en(o_osc_clock_en),
    .o_cpu_clock_in_en(o_cpu_clock_in_en), .o_system_clock_out_en(o_system_clock_out_en),
    .o_pll_en(o_pll_en), .o_pin_out(o_pin_out));
  wdlp_partner i_wdlp_partner (.i_clock(i_clock), .i_noise(noise), .i_quiet(32'h00000020),
    .o_gpio_a(gpio_a), .o_ext_reset_n(ext_n), .o_debug_wake_n(dbg_n), .o_cpu_irq_n(irq_n));

  // ----------------------------------------
  // clock, timeout, read-data monitor
  // ----------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    noise <= $random(seed);
    rd_seen <= i_rd;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  // read data stands only in the cycle after the strobe
  always @(negedge i_clock) if (rd_seen) check(o_rdata, exp_q.pop_front());

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clock);
    {i_rd, i_addr} <= {1'b1, a};
    exp_q.push_back(e);
    @(posedge i_clock);
    i_rd <= 1'b0;
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge i_clock);
    #1;
  endtask
  // waits for a watchdog pulse (sel 1 reset, 0 interrupt) and returns its length
  task automatic pulse(input bit sel, output int len);
    len = 0;
    while ((sel ? o_wd_reset_n : o_wd_wake_irq_n) !== 1'b0 && len < 600) begin
      wait_cyc(1);
      len++;
    end
    check(32'(sel ? o_wd_wake_irq_n : o_expander_irq_n), 32'(sel));
    len = 0;
    while ((sel ? o_wd_reset_n : o_wd_wake_irq_n) === 1'b0 && len < 600) begin
      wait_cyc(1);
      len++;
    end
  endtask
  task automatic wake_wait();
    for (int k = 0; k < 60 && o_cpu_clock_in_en !== 1'b1; k++) wait_cyc(1);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {i_resetn, i_wr, i_rd, i_clock_fail, i_addr, i_wdata} = '0;
    i_wd_clock_active = 1'b1;
    noise = 32'h0;
    v = $random(seed);
    i_pin_out = v;
    repeat (6) @(posedge i_clock);
    i_resetn <= 1'b1;
    wr(4'h7, v);
    rd(4'h7, 32'h0);
    wr(`WDLP_ADDR_WAKE_SEL, v);
    rd(`WDLP_ADDR_WAKE_SEL, v);
    $display("register map done");
    wr(`WDLP_ADDR_WD_CTRL, 32'h1);
    wait_cyc(40);
    wr(`WDLP_ADDR_WD_KEY, 32'h55);
    wr(`WDLP_ADDR_WD_KEY, 32'hAA);
    rd(`WDLP_ADDR_WD_COUNT, 32'h1);
    wr(`WDLP_ADDR_WD_KEY, 32'hAA);
    rd(`WDLP_ADDR_WD_COUNT, 32'h5);
    wr(`WDLP_ADDR_WD_CTRL, 32'h0);
    i_clock_fail <= 1'b1;
    wait_cyc(8);
    wr(`WDLP_ADDR_WD_CTRL, 32'h1);
    wait_cyc(30);
    rd(`WDLP_ADDR_WD_COUNT, 32'h0);
    i_clock_fail <= 1'b0;
    $display("key and limp done");
    pulse(1'b0, n);
    check(32'(n), 32'h200);
    wr(`WDLP_ADDR_WD_CTRL, 32'h3);
    pulse(1'b1, n);
    check(32'(n), 32'h200);
    wr(`WDLP_ADDR_WD_CTRL, 32'h0);
    $display("expiry done");
    pin_keep = i_pin_out;
    wr(`WDLP_ADDR_WAKE_SEL, 32'h20);
    wr(`WDLP_ADDR_LP_CTRL, 32'h11);
    wr(`WDLP_ADDR_LP_ENTER, 32'h0);
    wait_cyc(6);
    check(32'({o_osc_clock_en, o_cpu_clock_in_en}), 32'h2);
    @(posedge i_clock);
    i_pin_out <= ~pin_keep;
    wait_cyc(4);
    check(o_pin_out, pin_keep);
    i_wdlp_partner.hold_low(5, 2);
    wait_cyc(12);
    check(32'(o_cpu_clock_in_en), 32'h0);
    i_wdlp_partner.hold_low(5, 20);
    wake_wait();
    check(32'(o_cpu_clock_in_en), 32'h1);
    $display("standby done");
    @(posedge i_clock);
    i_wd_clock_active <= 1'b0;
    wait_cyc(6);
    wr(`WDLP_ADDR_LP_CTRL, 32'h2);
    wr(`WDLP_ADDR_LP_ENTER, 32'h0);
    wait_cyc(8);
    check(32'(o_pll_en), 32'h1);
    rd(`WDLP_ADDR_STATUS, 32'h19);
    i_wd_clock_active <= 1'b1;
    wait_cyc(6);
    wr(`WDLP_ADDR_LP_CTRL, 32'h3);
    wr(`WDLP_ADDR_LP_ENTER, 32'h0);
    wait_cyc(6);
    check(32'({o_pll_en, o_osc_clock_en, o_cpu_clock_in_en}), 32'h0);
    i_wdlp_partner.hold_low(32, 12);
    wake_wait();
    check(32'(o_cpu_clock_in_en), 32'h1);
    $display("halt done");
    wr(`WDLP_ADDR_STATUS, 32'h9);
    wr(`WDLP_ADDR_LP_CTRL, 32'h0);
    wr(`WDLP_ADDR_LP_ENTER, 32'h0);
    rd(`WDLP_ADDR_STATUS, 32'h20);
    i_wdlp_partner.hold_low(34, 12);
    wait_cyc(12);
    rd(`WDLP_ADDR_STATUS, 32'h10);
    wait_cyc(4);
    $display("idle done");
    test_done();
  end
endmodule // wdlp_top_tb
